// [spi_port_pkg.sv]
// How it works
// - Select idles high; its fall starts a transfer and aligns bit framing.
// - Select rising returns the slave to its initial receive state.
// - Select-framed slave operation only with slave mode field 0100.
// - Select low in that mode: shift both ways and drive data out.
// - Select high: stop driving data out at once, even mid-byte.
// - Port reset forces bit counter to 0: select high or enable cleared.
// - Master mode in sleep: clocks stop, transfer freezes, resumes on wake.
// - Slave shift register clocked only by the external serial clock.
// - Eight received bits set the interrupt flag, also during sleep.
// - Slave mode with interrupt enabled: completion wakes the device.
// - Port acts on pins only while enabled; reconfigure with enable clear.
// - With edge select set, output data is valid before the first edge.
// - Eight bits, msb first, go to receive buffer; buffer-full and flag set; with the buffer full and overwrite off, the old byte stays and overflow is set.
// - Buffer write during transfer is dropped, sets collision flag until cleared.
package spi_port_pkg;

   // register byte addresses
   localparam logic [7:0] ADDR_BUF  = 8'h00;
   localparam logic [7:0] ADDR_CON1 = 8'h04;
   localparam logic [7:0] ADDR_CON3 = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h0c;
   localparam logic [7:0] ADDR_IRQ  = 8'h10;

   // field positions
   localparam int CON1_COLL = 7;
   localparam int CON1_OV   = 6;
   localparam int CON1_EN   = 5;
   localparam int CON1_POL  = 4;
   localparam int STAT_PHS  = 7;
   localparam int STAT_CKE  = 6;
   localparam int STAT_FULL = 0;
   localparam int CON3_OVWR = 4;
   localparam int IRQ_FLAG  = 0;
   localparam int IRQ_EN    = 1;

   // writable masks and reset values
   localparam logic [7:0] CON1_RST  = 8'h00;
   localparam logic [7:0] CON3_RST  = 8'h00;
   localparam logic [7:0] STAT_RST  = 8'h00;
   localparam logic [7:0] CON3_MASK = 8'h10;
   localparam logic [7:0] STAT_MASK = 8'hc0;

   // port mode field codes
   localparam logic [3:0] MODE_M4     = 4'h0;
   localparam logic [3:0] MODE_M16    = 4'h1;
   localparam logic [3:0] MODE_M64    = 4'h2;
   localparam logic [3:0] MODE_SLV_SS = 4'h4;
   localparam logic [3:0] MODE_SLV    = 4'h5;

   // master half periods in device clocks
   localparam logic [5:0] HALF_M4  = 6'h02;
   localparam logic [5:0] HALF_M16 = 6'h08;
   localparam logic [5:0] HALF_M64 = 6'h20;

   // last bit index of a byte
   localparam logic [2:0] LAST_BIT = 3'h7;

   typedef enum logic [1:0] {
      MS_IDLE  = 2'b00,
      MS_LEAD  = 2'b01,
      MS_TRAIL = 2'b10
   } master_state_e;

endpackage

// [spi_bit_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module spi_bit_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   // two stages; only the second reads the first
   always_comb begin
      meta_next = d_i;
      q_next    = meta_reg;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_reg <= '0;
         q_reg    <= '0;
      end else begin
         meta_reg <= meta_next;
         q_reg    <= q_next;
      end
   end

   assign q_o = q_reg;

endmodule
`default_nettype wire

// [spi_port.sv]
`timescale 1ns/1ps
`default_nettype none
module spi_port (
   input  wire logic        CLOCK_I,
   input  wire logic        RESETN_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   input  wire logic        SCK_I,
   input  wire logic        SS_N_I,
   input  wire logic        SDI_I,
   output logic             SDO_O,
   output logic             SDO_OE_O,
   output logic             SCK_O,
   output logic             SCK_OE_O,
   input  wire logic        SLEEP_I,
   output logic             WAKE_O
);

   ////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic logic addr_hit(input logic [7:0] a);
      addr_hit = (a == spi_port_pkg::ADDR_BUF) || (a == spi_port_pkg::ADDR_CON1) ||
                 (a == spi_port_pkg::ADDR_CON3) || (a == spi_port_pkg::ADDR_STAT) ||
                 (a == spi_port_pkg::ADDR_IRQ);
   endfunction

   function automatic logic [5:0] half_count(input logic [3:0] m);
      case (m)
         spi_port_pkg::MODE_M4:  half_count = spi_port_pkg::HALF_M4;
         spi_port_pkg::MODE_M16: half_count = spi_port_pkg::HALF_M16;
         default:                half_count = spi_port_pkg::HALF_M64;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////
   // state

   logic [7:0]  con1_reg, con1_next;
   logic [7:0]  con3_reg, con3_next;
   logic [7:0]  stat_reg, stat_next;
   logic [7:0]  rxbuf_reg, rxbuf_next;
   logic [7:0]  tx_reg, tx_next;
   logic        flag_reg, flag_next;
   logic        ien_reg, ien_next;
   logic        wake_reg, wake_next;
   logic        pready_reg, pready_next;
   logic        pslverr_reg, pslverr_next;
   logic [31:0] prdata_reg, prdata_next;
   logic        rxt_d_reg, rxt_d_next;
   logic        sckoe_reg, sckoe_next;
   spi_port_pkg::master_state_e ms_reg, ms_next;
   logic [5:0]  mdiv_reg, mdiv_next;
   logic [2:0]  mcnt_reg, mcnt_next;
   logic [7:0]  mshift_reg, mshift_next;
   logic        msamp_reg, msamp_next;
   logic        msck_reg, msck_next;

   // link-side state
   logic [2:0]  lcnt_reg, lcnt_next;
   logic [6:0]  lshift_reg, lshift_next;
   logic        lbusy_reg, lbusy_next;
   logic [7:0]  lhold_reg, lhold_next;
   logic        ltog_reg, ltog_next;
   logic [2:0]  drv_reg, drv_next;

   ////////////////////////////////////////////////////////////////
   // configuration decode

   logic       en, pol, cke, ovwr_en, buf_full;
   logic       slave, ss_mode, master;
   logic [3:0] mode;
   assign en   = con1_reg[spi_port_pkg::CON1_EN];
   assign pol      = con1_reg[spi_port_pkg::CON1_POL];
   assign cke      = stat_reg[spi_port_pkg::STAT_CKE];
   assign ovwr_en  = con3_reg[spi_port_pkg::CON3_OVWR];
   assign buf_full = stat_reg[spi_port_pkg::STAT_FULL];
   assign mode = con1_reg[3:0];

   // select-framed slave only for code 0100
   assign ss_mode = en && (mode == spi_port_pkg::MODE_SLV_SS);
   assign slave   = ss_mode || (en && (mode == spi_port_pkg::MODE_SLV));
   assign master  = en && (mode <= spi_port_pkg::MODE_M64);

   ////////////////////////////////////////////////////////////////
   // crossings into the device clock

   logic ss_n_s, busy_s, rxt_s, sleep_s, sdi_s;

   spi_bit_sync #(.W(5)) u_sync (
      .clk_i   (CLOCK_I),
      .rst_n_i (RESETN_I),
      .d_i     ({SS_N_I, lbusy_reg, ltog_reg, SLEEP_I, SDI_I}),
      .q_o     ({ss_n_s, busy_s, rxt_s, sleep_s, sdi_s})
   );

   ////////////////////////////////////////////////////////////////
   // link clock and link reset

   logic sck_eff, link_rst_n;
   // sample edge becomes posedge: rising when polarity equals edge select
   assign sck_eff = SCK_I ^ (pol ^ cke);
   // select high or enable clear holds the slave at bit 0
   assign link_rst_n = RESETN_I && slave && !(ss_mode && SS_N_I);

   // shift in on the sample edge, msb first; sample phase ignored here
   always_comb begin
      lcnt_next   = lcnt_reg + 3'h1;
      lshift_next = {lshift_reg[5:0], SDI_I};
      lbusy_next  = (lcnt_reg != spi_port_pkg::LAST_BIT);
   end

   always_ff @(posedge sck_eff or negedge link_rst_n) begin
      if (!link_rst_n) begin
         lcnt_reg   <= 3'h0;
         lshift_reg <= 7'h00;
         lbusy_reg  <= 1'b0;
      end else begin
         lcnt_reg   <= lcnt_next;
         lshift_reg <= lshift_next;
         lbusy_reg  <= lbusy_next;
      end
   end

   // only the eighth sample hands a byte over; select resets never toggle
   always_comb begin
      lhold_next = lhold_reg;
      ltog_next  = ltog_reg;
      if (link_rst_n && lcnt_reg == spi_port_pkg::LAST_BIT) begin
         lhold_next = {lshift_reg, SDI_I};
         ltog_next  = !ltog_reg;
      end
   end

   always_ff @(posedge sck_eff or negedge RESETN_I) begin
      if (!RESETN_I) begin
         lhold_reg <= 8'h00;
         ltog_reg  <= 1'b0;
      end else begin
         lhold_reg <= lhold_next;
         ltog_reg  <= ltog_next;
      end
   end

   // drive edge moves the output bit to the next one
   always_comb begin
      drv_next = lcnt_reg;
   end

   always_ff @(negedge sck_eff or negedge link_rst_n) begin
      if (!link_rst_n) begin
         drv_reg <= 3'h0;
      end else begin
         drv_reg <= drv_next;
      end
   end

   ////////////////////////////////////////////////////////////////
   // bus slave and control registers

   logic acc, done, wr, rd, xfer_busy, rx_evt;
   logic [7:0] rx_byte, rd_mux;
   logic       m_done, m_start;

   assign acc  = PSEL_I && PENABLE_I;
   assign done = acc && pready_reg;
   assign wr   = done && PWRITE_I;
   assign rd   = done && !PWRITE_I;
   // a byte is in flight: master busy, slave mid-byte or selected
   assign xfer_busy = (master && ms_reg != spi_port_pkg::MS_IDLE) ||
                      (slave && (busy_s || (ss_mode && !ss_n_s)));
   assign rx_evt  = (slave && (rxt_s != rxt_d_reg)) || m_done;
   assign rx_byte = m_done ? {mshift_reg[6:0], msamp_reg} : lhold_reg;
   assign m_start = wr && PADDR_I == spi_port_pkg::ADDR_BUF && master &&
                    !xfer_busy && !con1_reg[spi_port_pkg::CON1_COLL];

   // read data selection
   always_comb begin
      case (PADDR_I)
         spi_port_pkg::ADDR_BUF:  rd_mux = rxbuf_reg;
         spi_port_pkg::ADDR_CON1: rd_mux = con1_reg;
         spi_port_pkg::ADDR_CON3: rd_mux = con3_reg;
         spi_port_pkg::ADDR_STAT: rd_mux = stat_reg;
         spi_port_pkg::ADDR_IRQ:  rd_mux = {6'h00, ien_reg, flag_reg};
         default:                 rd_mux = 8'h00;
      endcase
   end

   // register next values; hardware sets win over software clears
   always_comb begin
      con1_next    = con1_reg;
      con3_next    = con3_reg;
      stat_next    = stat_reg;
      rxbuf_next   = rxbuf_reg;
      tx_next      = tx_reg;
      flag_next    = flag_reg;
      ien_next     = ien_reg;
      pready_next  = acc && !pready_reg;
      pslverr_next = acc && !pready_reg && !addr_hit(PADDR_I);
      prdata_next  = prdata_reg;
      rxt_d_next   = rxt_s;
      wake_next    = flag_reg && ien_reg;
      sckoe_next   = master;
      if (acc && !pready_reg && !PWRITE_I) begin
         prdata_next = {24'h000000, rd_mux};
      end
      if (wr) begin
         unique case (PADDR_I)
            spi_port_pkg::ADDR_BUF: begin
               if (!con1_reg[spi_port_pkg::CON1_COLL] && !xfer_busy) begin
                  tx_next = PWDATA_I[7:0];
               end
            end
            spi_port_pkg::ADDR_CON1: con1_next = PWDATA_I[7:0];
            spi_port_pkg::ADDR_CON3: con3_next = PWDATA_I[7:0] & spi_port_pkg::CON3_MASK;
            spi_port_pkg::ADDR_STAT: begin
               stat_next = (PWDATA_I[7:0] & spi_port_pkg::STAT_MASK) |
                           (stat_reg & ~spi_port_pkg::STAT_MASK);
            end
            spi_port_pkg::ADDR_IRQ: begin
               flag_next = PWDATA_I[spi_port_pkg::IRQ_FLAG] && flag_reg;
               ien_next  = PWDATA_I[spi_port_pkg::IRQ_EN];
            end
            default: begin
            end
         endcase
      end
      if (rd && PADDR_I == spi_port_pkg::ADDR_BUF) begin
         stat_next[spi_port_pkg::STAT_FULL] = 1'b0;
      end
      // collision: write while busy is dropped and flagged
      if (wr && PADDR_I == spi_port_pkg::ADDR_BUF && xfer_busy) begin
         con1_next[spi_port_pkg::CON1_COLL] = 1'b1;
      end
      if (rx_evt) begin
         flag_next = 1'b1;
         if (buf_full && !ovwr_en) begin
            con1_next[spi_port_pkg::CON1_OV] = 1'b1;
         end else begin
            rxbuf_next = rx_byte;
            stat_next[spi_port_pkg::STAT_FULL] = 1'b1;
         end
      end
   end

   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         con1_reg    <= spi_port_pkg::CON1_RST;
         con3_reg    <= spi_port_pkg::CON3_RST;
         stat_reg    <= spi_port_pkg::STAT_RST;
         rxbuf_reg   <= 8'h00;
         tx_reg      <= 8'h00;
         flag_reg    <= 1'b0;
         ien_reg     <= 1'b0;
         wake_reg    <= 1'b0;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h00000000;
         rxt_d_reg   <= 1'b0;
         sckoe_reg   <= 1'b0;
      end else begin
         con1_reg    <= con1_next;
         con3_reg    <= con3_next;
         stat_reg    <= stat_next;
         rxbuf_reg   <= rxbuf_next;
         tx_reg      <= tx_next;
         flag_reg    <= flag_next;
         ien_reg     <= ien_next;
         wake_reg    <= wake_next;
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg  <= prdata_next;
         rxt_d_reg   <= rxt_d_next;
         sckoe_reg   <= sckoe_next;
      end
   end

   ////////////////////////////////////////////////////////////////
   // master engine; sample on leading edge, shift on trailing

   logic       run, half_end;
   assign run      = !sleep_s;
   assign half_end = (mdiv_reg == half_count(mode) - 6'h01);
   assign m_done   = (ms_reg == spi_port_pkg::MS_TRAIL) && run && half_end &&
                     (mcnt_reg == spi_port_pkg::LAST_BIT);

   always_comb begin
      ms_next     = ms_reg;
      mdiv_next   = mdiv_reg;
      mcnt_next   = mcnt_reg;
      mshift_next = mshift_reg;
      msamp_next  = msamp_reg;
      msck_next   = msck_reg;
      unique case (ms_reg)
         spi_port_pkg::MS_IDLE: begin
            msck_next = pol;
            if (m_start) begin
               mshift_next = PWDATA_I[7:0];
               mdiv_next   = 6'h00;
               mcnt_next   = 3'h0;
               ms_next     = spi_port_pkg::MS_LEAD;
            end
         end
         spi_port_pkg::MS_LEAD: begin
            if (run) begin
               mdiv_next = mdiv_reg + 6'h01;
               if (half_end) begin
                  mdiv_next  = 6'h00;
                  msck_next  = !pol;
                  msamp_next = sdi_s;
                  ms_next    = spi_port_pkg::MS_TRAIL;
               end
            end
         end
         spi_port_pkg::MS_TRAIL: begin
            if (run) begin
               mdiv_next = mdiv_reg + 6'h01;
               if (half_end) begin
                  mdiv_next   = 6'h00;
                  msck_next   = pol;
                  mshift_next = {mshift_reg[6:0], msamp_reg};
                  mcnt_next   = mcnt_reg + 3'h1;
                  ms_next     = m_done ? spi_port_pkg::MS_IDLE : spi_port_pkg::MS_LEAD;
               end
            end
         end
         default: ms_next = spi_port_pkg::MS_IDLE;
      endcase
      if (!master) begin
         ms_next   = spi_port_pkg::MS_IDLE;
         mcnt_next = 3'h0;
      end
   end

   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ms_reg     <= spi_port_pkg::MS_IDLE;
         mdiv_reg   <= 6'h00;
         mcnt_reg   <= 3'h0;
         mshift_reg <= 8'h00;
         msamp_reg  <= 1'b0;
         msck_reg   <= 1'b0;
      end else begin
         ms_reg     <= ms_next;
         mdiv_reg   <= mdiv_next;
         mcnt_reg   <= mcnt_next;
         mshift_reg <= mshift_next;
         msamp_reg  <= msamp_next;
         msck_reg   <= msck_next;
      end
   end

   ////////////////////////////////////////////////////////////////
   // outputs; data enable follows the select pin without delay

   assign PRDATA_O  = prdata_reg;
   assign PREADY_O  = pready_reg;
   assign PSLVERR_O = pslverr_reg;
   assign SCK_O     = msck_reg;
   assign SCK_OE_O  = sckoe_reg;
   assign WAKE_O    = wake_reg;
   // bit index held since the last drive edge: msb valid from select fall
   assign SDO_O     = master ? mshift_reg[7] : tx_reg[~drv_reg];
   assign SDO_OE_O  = master || (slave && !ss_mode) || (ss_mode && !SS_N_I);

   ////////////////////////////////////////////////////////////////
   // checks

   a_coll_on_busy: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
      wr && PADDR_I == spi_port_pkg::ADDR_BUF && xfer_busy |=>
         con1_reg[spi_port_pkg::CON1_COLL] && $stable(tx_reg))
      else $error("buffer write during transfer not flagged");

   a_coll_blocks: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
      con1_reg[spi_port_pkg::CON1_COLL] && wr && PADDR_I == spi_port_pkg::ADDR_BUF |=>
         $stable(tx_reg))
      else $error("write completed while collision flag set");

   a_rx_to_buf: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
      rx_evt && !(buf_full && !ovwr_en) |=> buf_full && rxbuf_reg == $past(rx_byte))
      else $error("received byte not delivered");

   a_flag_on_byte: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
      rx_evt |=> flag_reg ##1 wake_reg == ien_reg)
      else $error("interrupt flag not set on byte");

   a_sleep_freeze: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
      master && sleep_s && ms_reg != spi_port_pkg::MS_IDLE |=>
         $stable(mcnt_reg) && $stable(msck_reg) && $stable(mshift_reg))
      else $error("master moved during sleep");

   a_disable_idle: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
      !master |=> ms_reg == spi_port_pkg::MS_IDLE && mcnt_reg == 3'h0)
      else $error("master not reset by disable");

   a_sdo_float: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
      ss_mode && SS_N_I |-> !SDO_OE_O)
      else $error("data out driven while deselected");

   a_byte_wrap: assert property (@(posedge sck_eff) disable iff (!link_rst_n)
      lcnt_reg == spi_port_pkg::LAST_BIT |=> lcnt_reg == 3'h0 && ltog_reg != $past(ltog_reg))
      else $error("bit counter did not wrap after byte");

endmodule
`default_nettype wire

// [spi_bus_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module spi_bus_master_model (
   output logic      sck_o,
   output logic      ss_n_o,
   output logic      sdi_o,
   input  wire logic sdo_i,
   input  wire logic sdo_oe_i
);
   logic last_sdo;
   logic line;
   // an undriven data line shows the inverse of its last level
   always_comb line = sdo_oe_i ? sdo_i : ~last_sdo;
   initial begin
      sck_o = 1'b0;
      ss_n_o = 1'b1;
      sdi_o = 1'b0;
      last_sdo = 1'b0;
   end
   ////////////////////////////////////////////////////////////////
   // one framed transfer on a 30 ns link clock, msb first
   task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      #7;
      ss_n_o = 1'b0;
      sdi_o = tx[7];
      #15;
      for (int i = 0; i < nbits; i++) begin
         sck_o = 1'b1;
         rx = {rx[6:0], line};
         last_sdo = line;
         #15;
         sck_o = 1'b0;
         sdi_o = (i < 7) ? tx[6-i] : ~sdi_o;
         #15;
      end
      ss_n_o = 1'b1;
      sdi_o = ~sdi_o;
   endtask
endmodule
`default_nettype wire

// [spi_slave_select_sync_sleep_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module spi_slave_select_sync_sleep_tb;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        sck, ss_n, sdi, sdo, sdo_oe, sck_m, sck_m_oe, sleep, wake, bad;
   logic [32:0] exp_q[$];
   logic [7:0]  tx, rx, got, cfg;
   int          n_fail, total_checks, cycles, seed;

   spi_port i_spi_port (.CLOCK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .SCK_I(sck), .SS_N_I(ss_n), .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_O(sdo_oe),
      .SCK_O(sck_m), .SCK_OE_O(sck_m_oe), .SLEEP_I(sleep), .WAKE_O(wake));
   spi_bus_master_model i_spi_bus_master_model (.sck_o(sck), .ss_n_o(ss_n), .sdi_o(sdi),
      .sdo_i(sdo), .sdo_oe_i(sdo_oe));

   initial clk = 1'b0;
   always #10 clk = ~clk;
   ////////////////////////////////////////////////////////////////
   // compare, bus cycles and closing report
   task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
      exp_q.push_back({err, exp});
      apb(1'b0, a, 32'h0);
   endtask
   task automatic wait_wake;
      int n;
      n = 0;
      while (wake !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      check("wake", 33'(wake), 33'h1);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // read results are compared against the oldest queued note
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         check("read", {pslverr, prdata}, exp_q.pop_front());
      end
   end
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         finish_test();
      end
   end
   ////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      seed = 95130;
      {rst_n, psel, penable, pwrite, paddr, pwdata, sleep} = '0;
      cfg = (8'h01 << spi_port_pkg::CON1_EN) | {4'h0, spi_port_pkg::MODE_SLV_SS};
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rd(spi_port_pkg::ADDR_CON1, 32'(spi_port_pkg::CON1_RST), 1'b0);
      rd(spi_port_pkg::ADDR_CON3, 32'(spi_port_pkg::CON3_RST), 1'b0);
      rd(spi_port_pkg::ADDR_STAT, 32'(spi_port_pkg::STAT_RST), 1'b0);
      rd(8'h14, 32'h0, 1'b1);
      wr(spi_port_pkg::ADDR_STAT, 32'h0);
      wr(spi_port_pkg::ADDR_CON1, 32'(cfg));
      wr(spi_port_pkg::ADDR_IRQ, 32'h2);
      check("oe idle", 33'(sdo_oe), 33'h0);
      $display("test reset and config done");
      for (int k = 0; k < 3; k++) begin
         tx = 8'($random(seed));
         rx = 8'($random(seed));
         if (k == 1) begin
            i_spi_bus_master_model.xfer(~rx, 5, got);
            #1;
            check("oe cut", 33'(sdo_oe), 33'h0);
            repeat (10) @(posedge clk);
            rd(spi_port_pkg::ADDR_IRQ, 32'h2, 1'b0);
            rd(spi_port_pkg::ADDR_STAT, 32'h0, 1'b0);
         end
         sleep <= (k == 2);
         wr(spi_port_pkg::ADDR_BUF, 32'(tx));
         fork
            i_spi_bus_master_model.xfer(rx, 8, got);
            begin
               #40;
               check("oe active", 33'(sdo_oe), 33'h1);
            end
         join
         check("master rx", 33'(got), 33'(tx));
         wait_wake();
         sleep <= 1'b0;
         rd(spi_port_pkg::ADDR_STAT, 32'h1, 1'b0);
         rd(spi_port_pkg::ADDR_IRQ, 32'h3, 1'b0);
         rd(spi_port_pkg::ADDR_BUF, 32'(rx), 1'b0);
         rd(spi_port_pkg::ADDR_STAT, 32'h0, 1'b0);
         wr(spi_port_pkg::ADDR_IRQ, 32'h2);
         $display("test byte %0d done", k);
      end
      tx = 8'($random(seed));
      wr(spi_port_pkg::ADDR_BUF, 32'(tx));
      fork
         i_spi_bus_master_model.xfer(rx, 8, got);
         begin
            repeat (4) @(posedge clk);
            wr(spi_port_pkg::ADDR_BUF, 32'(~tx));
         end
      join
      check("collision rx", 33'(got), 33'(tx));
      wait_wake();
      rd(spi_port_pkg::ADDR_CON1, 32'(cfg | 8'h80), 1'b0);
      wr(spi_port_pkg::ADDR_BUF, 32'(~tx));
      rd(spi_port_pkg::ADDR_BUF, 32'(rx), 1'b0);
      wr(spi_port_pkg::ADDR_IRQ, 32'h2);
      wr(spi_port_pkg::ADDR_CON1, 32'(cfg));
      rd(spi_port_pkg::ADDR_CON1, 32'(cfg), 1'b0);
      $display("test collision done");
      wr(spi_port_pkg::ADDR_CON1, 32'(spi_port_pkg::MODE_SLV));
      wr(spi_port_pkg::ADDR_CON1, 32'(8'h20 | {4'h0, spi_port_pkg::MODE_SLV}));
      @(posedge clk);
      check("oe no select", 33'(sdo_oe), 33'h1);
      wr(spi_port_pkg::ADDR_CON1, 32'h0);
      @(posedge clk);
      check("oe disabled", 33'(sdo_oe), 33'h0);
      wr(spi_port_pkg::ADDR_CON1, 32'(8'h20 | {4'h0, spi_port_pkg::MODE_M4}));
      repeat (2) @(posedge clk);
      check("master oe", 33'(sck_m_oe), 33'h1);
      sleep <= 1'b1;
      repeat (3) @(posedge clk);
      wr(spi_port_pkg::ADDR_BUF, 32'h5a);
      bad = 1'b0;
      repeat (30) begin
         @(posedge clk);
         if (sck_m !== 1'b0) begin
            bad = 1'b1;
         end
      end
      check("frozen", 33'(bad), 33'h0);
      sleep <= 1'b0;
      wait_wake();
      rd(spi_port_pkg::ADDR_IRQ, 32'h3, 1'b0);
      wr(spi_port_pkg::ADDR_IRQ, 32'h1);
      repeat (2) @(posedge clk);
      check("no wake", 33'(wake), 33'h0);
      $display("test master sleep done");
      repeat (5) @(posedge clk);
      finish_test();
   end
endmodule
`default_nettype wire
